// ==== common/rcc_cfg.svh ====
// constants of the reset cause block: offsets, bit positions, reset values
// assumes 32-bit apb data, each register one aligned word
`ifndef RCC_CFG_SVH
`define RCC_CFG_SVH

// apb address width and register byte offsets
`define RCC_ADDR_W 12
`define RCC_OFF_CAUSE 12'h000
`define RCC_OFF_IRQ_STAT 12'h004
`define RCC_OFF_IRQ_MASK 12'h008
`define RCC_OFF_STATUS 12'h00C

// bit positions inside reset_cause_control
`define RCC_BIT_TRAP 15
`define RCC_BIT_PIN 7
`define RCC_BIT_WDT_SOFT 5
`define RCC_BIT_BROWNOUT 1
`define RCC_BIT_POWERON 0

// power-on value and software writable bits of reset_cause_control
`define RCC_CAUSE_RESET 16'h0003
`define RCC_CAUSE_WMASK 16'h80A3

// event bits of irq status and irq mask
`define RCC_NUM_EVENTS 3
`define RCC_EV_TRAP 0
`define RCC_EV_PIN 1
`define RCC_EV_BROWNOUT 2
`define RCC_IRQ_STAT_RESET 3'h0
`define RCC_IRQ_MASK_RESET 3'h0

// status register bits
`define RCC_ST_WDT_ON 0
`define RCC_ST_FUSE 1
`define RCC_ST_PIN_LEVEL 2

// watchdog enable after power-on, before the fuse is sampled
`define RCC_WDT_EN_RESET 1'h1

`endif

// ==== common/rcc_pkg.sv ====
// types of the reset cause block: apb carriers, bus phase, state record
// assumes rcc_cfg.svh is on the include path
package rcc_pkg;
  `include "rcc_cfg.svh"

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`RCC_ADDR_W-1:0] paddr;
    logic [3:0] pstrb;
    logic [31:0] pwdata;
  } apb_req_s;

  // apb answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

  // phase of the slave answer
  typedef enum logic {
    PH_IDLE,
    PH_ACK
  } bus_phase_e;

  // whole state of the block
  typedef struct packed {
    bus_phase_e phase;
    logic [15:0] cause;
    logic [`RCC_NUM_EVENTS-1:0] irq_stat;
    logic [`RCC_NUM_EVENTS-1:0] irq_mask;
    logic pin_prev;
    logic wdt_en;
    logic irq;
    apb_rsp_s rsp;
  } state_s;
endpackage : rcc_pkg

// ==== hw/rcc_sync2.sv ====
// two flip-flop synchroniser for levels from outside the pclk domain
// assumes inputs are slow levels; no pulse shorter than two clocks matters
`timescale 1ns/1ps
module rcc_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // async levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg; // first stage, read by the second only

  // two stages, reset to the idle level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : rcc_sync2

// ==== hw/reset_cause_status_register.sv ====
// reset cause and watchdog enable register behind an apb slave
// assumes presetn is the power-on reset; trap conflict and brown-out causes arrive as
// one-cycle pulses from the reset controller, which leaves this block alive
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "rcc_cfg.svh"

// What this block does
// - trap conflict reset sets bit 15
// - master clear pin reset sets bit 7
// - software sets or clears flags, never resets
// - fuse at one forces watchdog always enabled
module reset_cause_status_register
  import rcc_pkg::*;
(
  // clock and power-on reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire apb_req_s apb_req,
  output apb_rsp_s apb_rsp,
  // reset cause events from the reset controller, pclk domain
  input wire logic trap_conflict_reset,
  input wire logic brownout_reset,
  // pins, asynchronous to pclk
  input wire logic master_clear_pin_n,
  input wire logic watchdog_fuse_enable,
  // outputs to the system
  output logic watchdog_enable,
  output logic irq
);

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  state_s s_reg; // registered state
  state_s s_next; // next state
  logic [1:0] pins_sync; // synchronised pins
  logic pin_n_sync; // master clear pin, active low
  logic fuse_sync; // watchdog fuse level
  logic pin_assert; // master clear pin went low
  logic [`RCC_NUM_EVENTS-1:0] events; // hardware events this cycle
  logic access; // access phase of a transfer
  logic hit_cause; // address decodes
  logic hit_stat;
  logic hit_mask;
  logic hit_status;
  logic mapped; // address is one of ours
  logic [31:0] rd_data; // read mux
  logic [31:0] lanes; // byte lane mask of the write
  logic do_write; // write takes effect this edge
  logic [15:0] cause_wr; // cause after the software write
  logic [`RCC_NUM_EVENTS-1:0] stat_clr; // write-one-to-clear bits
  logic [`RCC_NUM_EVENTS-1:0] mask_wr; // mask after the software write

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------

  // word address compare, byte offset bits ignored
  function automatic logic reg_hit(
    input logic [`RCC_ADDR_W-1:0] addr,
    input logic [`RCC_ADDR_W-1:0] off
  );
    reg_hit = (addr[`RCC_ADDR_W-1:2] == off[`RCC_ADDR_W-1:2]);
  endfunction : reg_hit

  // expand pstrb into a 32-bit lane mask
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    lane_mask = m;
  endfunction : lane_mask

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------

  // idle levels: pin released high, fuse unprogrammed high
  rcc_sync2 #(
    .WIDTH(2),
    .RESET_VAL(2'h3)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({watchdog_fuse_enable, master_clear_pin_n}),
    .sync_out(pins_sync)
  );

  assign pin_n_sync = pins_sync[0];
  assign fuse_sync = pins_sync[1];

  // ------------------------------------------------------------------
  // event detection
  // ------------------------------------------------------------------

  // falling edge of the synchronised pin is a master clear reset
  assign pin_assert = s_reg.pin_prev & ~pin_n_sync;

  // gather events in irq bit order
  always_comb begin
    events = '0;
    events[`RCC_EV_TRAP] = trap_conflict_reset;
    events[`RCC_EV_PIN] = pin_assert;
    events[`RCC_EV_BROWNOUT] = brownout_reset;
  end

  // ------------------------------------------------------------------
  // address decode and read mux
  // ------------------------------------------------------------------

  // decode of the four word registers
  always_comb begin
    hit_cause = reg_hit(apb_req.paddr, `RCC_OFF_CAUSE);
    hit_stat = reg_hit(apb_req.paddr, `RCC_OFF_IRQ_STAT);
    hit_mask = reg_hit(apb_req.paddr, `RCC_OFF_IRQ_MASK);
    hit_status = reg_hit(apb_req.paddr, `RCC_OFF_STATUS);
    mapped = hit_cause | hit_stat | hit_mask | hit_status;
    access = apb_req.psel & apb_req.penable;
  end

  // read data, upper bits zero, unmapped reads zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit_cause) begin
      rd_data[15:0] = s_reg.cause;
    end else if (hit_stat) begin
      rd_data[`RCC_NUM_EVENTS-1:0] = s_reg.irq_stat;
    end else if (hit_mask) begin
      rd_data[`RCC_NUM_EVENTS-1:0] = s_reg.irq_mask;
    end else if (hit_status) begin
      // live view of the watchdog and pins
      rd_data[`RCC_ST_WDT_ON] = s_reg.wdt_en;
      rd_data[`RCC_ST_FUSE] = fuse_sync;
      rd_data[`RCC_ST_PIN_LEVEL] = pin_n_sync;
    end
  end

  // ------------------------------------------------------------------
  // software write values
  // ------------------------------------------------------------------

  // a write lands on the edge that samples pready high
  assign do_write = access & apb_req.pwrite & (s_reg.phase == PH_ACK);
  assign lanes = lane_mask(apb_req.pstrb);

  // merge of the write data into each register
  always_comb begin
    cause_wr = s_reg.cause;
    stat_clr = '0;
    mask_wr = s_reg.irq_mask;
    if (do_write && hit_cause) begin
      // writable flags take the data, others keep zero
      cause_wr = (s_reg.cause & ~(lanes[15:0] & `RCC_CAUSE_WMASK))
               | (apb_req.pwdata[15:0] & lanes[15:0]
                  & `RCC_CAUSE_WMASK);
    end
    if (do_write && hit_stat) begin
      // ones written clear the sticky bits
      stat_clr = apb_req.pwdata[`RCC_NUM_EVENTS-1:0]
               & lanes[`RCC_NUM_EVENTS-1:0];
    end
    if (do_write && hit_mask) begin
      // mask bits replaced under the low lane
      mask_wr = lanes[0] ? apb_req.pwdata[`RCC_NUM_EVENTS-1:0]
                         : s_reg.irq_mask;
    end
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;

    // track the pin for edge detection
    s_next.pin_prev = pin_n_sync;

    // apb answer, one wait cycle before pready
    case (s_reg.phase)
      PH_IDLE: begin
        if (access) begin
          // answer with data registered from the current address
          s_next.phase = PH_ACK;
          s_next.rsp.pready = 1'h1;
          s_next.rsp.pslverr = ~mapped;
          s_next.rsp.prdata = rd_data;
        end else begin
          s_next.rsp.pready = 1'h0;
          s_next.rsp.pslverr = 1'h0;
        end
      end
      PH_ACK: begin
        // transfer ends on this edge
        s_next.phase = PH_IDLE;
        s_next.rsp.pready = 1'h0;
        s_next.rsp.pslverr = 1'h0;
        s_next.rsp.prdata = 32'h0000_0000;
      end
      default: begin
        // stray phase, return to idle
        s_next.phase = PH_IDLE;
        s_next.rsp = '0;
      end
    endcase

    // software value first, hardware set wins over a software clear
    s_next.cause = cause_wr;
    if (trap_conflict_reset) begin
      s_next.cause[`RCC_BIT_TRAP] = 1'h1;
    end
    if (pin_assert) begin
      s_next.cause[`RCC_BIT_PIN] = 1'h1;
    end
    if (brownout_reset) begin
      s_next.cause[`RCC_BIT_BROWNOUT] = 1'h1;
    end

    // sticky event bits, set beats clear in the same cycle
    for (int i = 0; i < `RCC_NUM_EVENTS; i++) begin
      s_next.irq_stat[i] = (s_reg.irq_stat[i] & ~stat_clr[i]) | events[i];
    end
    s_next.irq_mask = mask_wr;

    // level interrupt, registered
    s_next.irq = |(s_next.irq_stat & s_next.irq_mask);

    // fuse at one overrides the software enable
    s_next.wdt_en = fuse_sync | s_next.cause[`RCC_BIT_WDT_SOFT];
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------

  // power-on reset loads the power-on flag values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg.phase <= PH_IDLE;
      s_reg.cause <= `RCC_CAUSE_RESET;
      s_reg.irq_stat <= `RCC_IRQ_STAT_RESET;
      s_reg.irq_mask <= `RCC_IRQ_MASK_RESET;
      s_reg.pin_prev <= 1'h1;
      s_reg.wdt_en <= `RCC_WDT_EN_RESET;
      s_reg.irq <= 1'h0;
      s_reg.rsp <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ------------------------------------------------------------------
  // outputs, all straight from the state register
  // ------------------------------------------------------------------
  assign apb_rsp = s_reg.rsp;
  assign watchdog_enable = s_reg.wdt_en;
  assign irq = s_reg.irq;

endmodule : reset_cause_status_register

// ==== test/rcc_check_assertions.sv ====
// checker of the reset cause block, bound to its top module
// assumes only top ports are seen and no event lands on a read
`timescale 1ns/1ps
`include "rcc_cfg.svh"
module rcc_check
  import rcc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bus, events and watchdog
  input wire apb_req_s apb_req,
  input wire apb_rsp_s apb_rsp,
  input wire logic trap_conflict_reset,
  input wire logic watchdog_fuse_enable,
  input wire logic watchdog_enable,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_cause; // write to the cause register completes
  logic cause_rd; // read answer of the cause register
  logic trap_reg; // expected trap flag
  assign wr_cause = apb_req.psel && apb_req.penable && apb_rsp.pready &&
    apb_req.pwrite && apb_req.paddr == `RCC_OFF_CAUSE;
  assign cause_rd = apb_rsp.pready && !apb_req.pwrite &&
    apb_req.paddr == `RCC_OFF_CAUSE;
  // shadow of the trap flag; an event beats a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_reg <= 1'b0;
    end else if (trap_conflict_reset) begin
      trap_reg <= 1'b1;
    end else if (wr_cause && apb_req.pstrb[1]) begin
      trap_reg <= apb_req.pwdata[15];
    end
  end
  poweron_outputs_a: assert property (
    $rose(presetn) |-> !irq && watchdog_enable && !apb_rsp.pready)
    else $error("outputs wrong after power-on");
  trap_flag_read_a: assert property (
    cause_rd |-> apb_rsp.prdata[15] == trap_reg)
    else $error("trap flag read differs");
  soft_wdt_on_a: assert property (
    wr_cause && apb_req.pstrb[0] && apb_req.pwdata[5] |-> ##[1:2]
    watchdog_enable) else $error("soft enable not taken");
  soft_wdt_off_a: assert property (
    (!watchdog_fuse_enable)[*4] ##0 wr_cause && apb_req.pstrb[0] &&
    !apb_req.pwdata[5] |-> ##[1:2] !watchdog_enable)
    else $error("soft disable not taken");
  fuse_forces_wdt_a: assert property (
    watchdog_fuse_enable[*4] |=> watchdog_enable)
    else $error("fuse did not force watchdog on");
endmodule : rcc_check

bind reset_cause_status_register rcc_check chk_i (.pclk(pclk),
  .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .trap_conflict_reset(trap_conflict_reset),
  .watchdog_fuse_enable(watchdog_fuse_enable),
  .watchdog_enable(watchdog_enable), .irq(irq));

// ==== test/reset_cause_status_register_tb.sv ====
// self-checking bench of the reset cause block over apb
// assumes the checker is bound in its own file; no partner model
`timescale 1ns/1ps
`include "rcc_cfg.svh"
module reset_cause_status_register_tb
  import rcc_pkg::*;
;
  logic pclk = 1'b0; // bench clock
  logic presetn; // power-on reset
  apb_req_s req; // bus request
  apb_rsp_s rsp; // bus answer
  logic trap_ev; // trap conflict pulse
  logic bo_ev; // brown-out pulse
  logic pin_n; // master clear pin
  logic fuse; // watchdog fuse
  logic wdt; // watchdog enable out
  logic irq; // interrupt out
  logic slverr; // last error answer
  logic [31:0] rd; // last read data
  int err_total;
  int tests_run;
  always #5 pclk = ~pclk;
  reset_cause_status_register uut (.pclk(pclk), .presetn(presetn),
    .apb_req(req), .apb_rsp(rsp), .trap_conflict_reset(trap_ev),
    .brownout_reset(bo_ev), .master_clear_pin_n(pin_n),
    .watchdog_fuse_enable(fuse), .watchdog_enable(wdt), .irq(irq));
  // compare and count
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  // one apb transfer; only the hang guard ends a wait for pready
  task automatic xfer(logic wr, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    req <= '{1'b1, 1'b0, wr, a, 4'hF, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    slverr = rsp.pslverr;
    req <= '0;
  endtask : xfer
  // wait some edges
  task automatic tick(int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  // one-cycle event pulse, 0 trap, 1 brown-out
  task automatic ev(int k);
    @(posedge pclk);
    if (k == 0) trap_ev <= 1'b1;
    else bo_ev <= 1'b1;
    @(posedge pclk);
    trap_ev <= 1'b0;
    bo_ev <= 1'b0;
    tick(3);
  endtask : ev
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  // hang guard
  initial begin
    #50us;
    err_total++;
    wrap_up();
  end
  // main sequence
  initial begin
    presetn = 1'b0;
    req = '0;
    trap_ev = 1'b0;
    bo_ev = 1'b0;
    pin_n = 1'b1;
    fuse = 1'b1;
    err_total = 0;
    tests_run = 0;
    tick(12);
    presetn <= 1'b1;
    xfer(0, `RCC_OFF_CAUSE, 0);
    chk("cause", rd, 32'h0003);
    chk("wdt", wdt, 1);
    xfer(0, `RCC_OFF_STATUS, 0);
    chk("status", rd, 32'h7);
    $display("end power-on test");
    xfer(1, `RCC_OFF_CAUSE, 0);
    xfer(0, `RCC_OFF_CAUSE, 0);
    chk("cause", rd, 32'h0);
    xfer(1, `RCC_OFF_IRQ_MASK, 32'h5);
    xfer(0, `RCC_OFF_IRQ_MASK, 0);
    chk("mask", rd, 32'h5);
    ev(0);
    xfer(0, `RCC_OFF_CAUSE, 0);
    chk("cause", rd, 32'h8000);
    chk("irq", irq, 1);
    xfer(1, `RCC_OFF_IRQ_STAT, 32'h1);
    tick(1);
    chk("irq", irq, 0);
    $display("end trap test");
    pin_n <= 1'b0;
    tick(6);
    pin_n <= 1'b1;
    tick(4);
    xfer(0, `RCC_OFF_CAUSE, 0);
    chk("cause", rd, 32'h8080);
    chk("irq", irq, 0);
    ev(1);
    xfer(0, `RCC_OFF_IRQ_STAT, 0);
    chk("stat", rd, 32'h6);
    chk("irq", irq, 1);
    xfer(1, `RCC_OFF_IRQ_STAT, 32'h7);
    tick(1);
    chk("irq", irq, 0);
    $display("end pin test");
    xfer(1, `RCC_OFF_CAUSE, 32'hFFFF);
    xfer(0, `RCC_OFF_CAUSE, 0);
    chk("cause", rd, 32'h80A3);
    xfer(0, `RCC_OFF_IRQ_STAT, 0);
    chk("stat", rd, 32'h0);
    $display("end software test");
    fuse <= 1'b0;
    tick(5);
    xfer(0, `RCC_OFF_STATUS, 0);
    chk("status", rd, 32'h5);
    xfer(1, `RCC_OFF_STATUS, 32'h0);
    chk("slverr", slverr, 0);
    xfer(1, `RCC_OFF_CAUSE, 0);
    tick(3);
    chk("wdt", wdt, 0);
    xfer(1, `RCC_OFF_CAUSE, 32'h0020);
    tick(3);
    chk("wdt", wdt, 1);
    xfer(1, `RCC_OFF_CAUSE, 0);
    fuse <= 1'b1;
    tick(6);
    chk("wdt", wdt, 1);
    xfer(0, 12'h010, 0);
    chk("slverr", slverr, 1);
    $display("end watchdog test");
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    xfer(0, `RCC_OFF_CAUSE, 0);
    chk("cause", rd, 32'h0003);
    $display("end second reset test");
    wrap_up();
  end
endmodule : reset_cause_status_register_tb
